// >>> verilog/asr_map.svh
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define ASR_CH_LAST      6'h3F
`define ASR_WBIT_LONG    5'h13
`define ASR_WBIT_SHORT   5'h0F
`define ASR_FRM_LONG     11'h500
`define ASR_FRM_SHORT    11'h400

// ----------------------------------------------------------------
// configuration word and readback stream
// ----------------------------------------------------------------
`define ASR_CFG_RST      16'h0000
`define ASR_CFG_LAST     4'hF
`define ASR_FMT_BIT      8
`define ASR_REV_ID       4'h5
`define ASR_RB_ZERO_L    10'h140
`define ASR_RB_ZERO_S    10'h100
`define ASR_RB_LEN_L     10'h280
`define ASR_RB_LEN_S     10'h200
`define ASR_CHK_L        72'h30F066012480F69055
`define ASR_CHK_S        56'h30F066012480F6
`define ASR_CHK_W_L      10'h048
`define ASR_CHK_W_S      10'h038

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASR_CLK_NS       8
`define ASR_HOLD_NS      400
`define ASR_HOLD_CYC     ((`ASR_HOLD_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

`endif

// >>> verilog/asr_pkg.sv
`default_nettype none

package asr_pkg;
	// operating mode of the block
	typedef enum logic [1:0] {ASR_CFG, ASR_RB, ASR_RUN} asr_mode_t;
endpackage

`default_nettype wire

// >>> verilog/asr_readout.sv
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"

module asr_readout (
	// system clock, reset, enable
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// readout link clock
	input  wire logic        readout_clk_i,
	// results from the conversion engine
	input  wire logic        res_wr_i,
	input  wire logic [5:0]  res_ch_i,
	input  wire logic [19:0] res_data_i,
	input  wire logic        frame_done_i,
	// device pins
	input  wire logic        integrate_select_i,
	input  wire logic        cfg_shift_clk_i,
	input  wire logic        cfg_serial_in_i,
	input  wire logic        chain_in_i,
	output logic             data_ready_n_o,
	output logic             serial_out_o,
	// status toward the rest of the device
	output logic             overrun_o,
	output logic [15:0]      cfg_word_o
);

	// ----------------------------------------------------------------
	// system clock domain
	// ----------------------------------------------------------------
	logic [19:0]         mem_ff [0:1][0:63];
	logic                integrate_select_s1_ff, integrate_select_s2_ff, integrate_select_s3_ff;
	logic                cfgc_s1_ff, cfgc_s2_ff, cfgc_s3_ff;
	logic                cfgd_s1_ff, cfgd_s2_ff;
	logic                st_s1_ff, st_s2_ff;
	logic                od_s1_ff, od_s2_ff;
	logic [15:0]         cfg_sr_ff;
	logic [15:0]         cfg_ff;
	logic [3:0]          cfg_cnt_ff;
	asr_pkg::asr_mode_t  mode_ff;
	logic                rd_bank_ff;
	logic                lrst_n_ff;
	logic [6:0]          hold_cnt_ff;
	logic                data_ready_n_ff;
	logic                have_frame_ff;
	logic                overrun_ff;
	logic                rb_sel_ff;
	logic                cfg_fall;
	logic                integrate_select_edge;
	logic                frame_go;
	logic                cfg_take;
	logic                cfg_commit;
	logic                fmt;

	// link domain state
	logic [5:0]          own_word_ff;
	logic [4:0]          own_bit_ff;
	logic                own_done_ff;
	logic                started_ff;
	logic                dat_out_ff;
	logic [1279:0]       chain_sr_ff;
	logic [9:0]          rb_idx_ff;
	logic                rb_rep_ff;
	logic                rb_pass_ff;
	logic                rb_out_ff;
	logic [4:0]          wbit_last;
	logic                own_last;
	logic                own_bit_w;
	logic [10:0]         tap_d;
	logic [10:0]         tap_r;
	logic                chain_tap_d;
	logic                chain_tap_r;
	logic [9:0]          rb_len_last;

	// edge decoding on synchronised pins
	assign cfg_fall   = cfgc_s3_ff & ~cfgc_s2_ff;
	assign integrate_select_edge  = integrate_select_s3_ff ^ integrate_select_s2_ff;
	assign frame_go   = ce_i & frame_done_i & (mode_ff == asr_pkg::ASR_RUN);
	assign cfg_take   = ce_i & cfg_fall & (mode_ff == asr_pkg::ASR_CFG);
	assign cfg_commit = cfg_take & (cfg_cnt_ff == `ASR_CFG_LAST);
	assign fmt        = cfg_ff[`ASR_FMT_BIT];

	// result store: engine fills one bank while the link reads the other
	always_ff @(posedge clock_i)
	begin
		if (ce_i && res_wr_i)
			mem_ff[~rd_bank_ff][res_ch_i] <= res_data_i;
	end

	// two-stage synchronisers for pins and link-domain levels
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			{integrate_select_s1_ff, integrate_select_s2_ff, integrate_select_s3_ff} <= 3'h0;
			{cfgc_s1_ff, cfgc_s2_ff, cfgc_s3_ff} <= 3'h0;
			{cfgd_s1_ff, cfgd_s2_ff, st_s1_ff, st_s2_ff} <= 4'h0;
			{od_s1_ff, od_s2_ff} <= 2'h0;
		end
		else if (ce_i)
		begin
			{integrate_select_s3_ff, integrate_select_s2_ff, integrate_select_s1_ff} <= {integrate_select_s2_ff, integrate_select_s1_ff, integrate_select_i};
			{cfgc_s3_ff, cfgc_s2_ff, cfgc_s1_ff} <= {cfgc_s2_ff, cfgc_s1_ff, cfg_shift_clk_i};
			{cfgd_s2_ff, cfgd_s1_ff} <= {cfgd_s1_ff, cfg_serial_in_i};
			{st_s2_ff, st_s1_ff} <= {st_s1_ff, started_ff};
			{od_s2_ff, od_s1_ff} <= {od_s1_ff, own_done_ff};
		end
	end

	// configuration shift: MSB first, the word lands only when complete
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cfg_sr_ff  <= `ASR_CFG_RST;
			cfg_ff     <= `ASR_CFG_RST;
			cfg_cnt_ff <= 4'h0;
		end
		else if (cfg_take)
		begin
			cfg_sr_ff  <= {cfg_sr_ff[14:0], cfgd_s2_ff};
			cfg_cnt_ff <= cfg_cnt_ff + 4'h1;
			if (cfg_commit)
				cfg_ff <= {cfg_sr_ff[14:0], cfgd_s2_ff};
		end
	end

	// mode: reset leaves config, a full write opens readback,
	// a select toggle starts normal conversion
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			mode_ff <= asr_pkg::ASR_CFG;
		else if (ce_i)
			case (mode_ff)
				asr_pkg::ASR_CFG: if (cfg_commit) mode_ff <= asr_pkg::ASR_RB;
				asr_pkg::ASR_RB:  if (integrate_select_edge) mode_ff <= asr_pkg::ASR_RUN;
				asr_pkg::ASR_RUN: mode_ff <= asr_pkg::ASR_RUN;
				default:          mode_ff <= asr_pkg::ASR_CFG;
			endcase
	end

	// frame hand-off; the link side idles here, so a one-cycle
	// asynchronous clear is the only way to rewind its counters
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rd_bank_ff      <= 1'b0;
			lrst_n_ff       <= 1'b0;
			hold_cnt_ff     <= 7'h00;
			data_ready_n_ff <= 1'b1;
			have_frame_ff   <= 1'b0;
			overrun_ff      <= 1'b0;
			rb_sel_ff       <= 1'b0;
		end
		else if (ce_i)
		begin
			lrst_n_ff <= ~(frame_go | cfg_commit);
			rb_sel_ff <= (mode_ff == asr_pkg::ASR_RB) | cfg_commit;
			if (frame_go)
			begin
				rd_bank_ff      <= ~rd_bank_ff;
				have_frame_ff   <= 1'b1;
				data_ready_n_ff <= 1'b1;
				hold_cnt_ff     <= 7'(`ASR_HOLD_CYC);
			end
			else if (hold_cnt_ff != 7'h00)
			begin
				hold_cnt_ff <= hold_cnt_ff - 7'h01;
				if (hold_cnt_ff == 7'h01)
					data_ready_n_ff <= 1'b0;
			end
			else if (st_s2_ff)
				data_ready_n_ff <= 1'b1;
			if (frame_go && have_frame_ff && !od_s2_ff)
				overrun_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// readout link domain
	// ----------------------------------------------------------------
	// bank store, width and mode are only rewritten while the link clock
	// is held quiet, so the link reads them without a crossing stage
	assign wbit_last   = fmt ? `ASR_WBIT_LONG : `ASR_WBIT_SHORT;
	assign own_last    = (own_word_ff == `ASR_CH_LAST) && (own_bit_ff == wbit_last);
	assign own_bit_w   = mem_ff[rd_bank_ff][own_word_ff][5'h13 - own_bit_ff];
	assign tap_d       = (fmt ? `ASR_FRM_LONG : `ASR_FRM_SHORT) - 11'h002;
	assign tap_r       = (fmt ? `ASR_FRM_LONG : `ASR_FRM_SHORT) - 11'h001;
	assign chain_tap_d = chain_sr_ff[tap_d];
	assign chain_tap_r = chain_sr_ff[tap_r];
	assign rb_len_last = (fmt ? `ASR_RB_LEN_L : `ASR_RB_LEN_S) - 10'h001;

	// readback bit at a position within one pass
	function automatic logic rb_bit(input logic [9:0] idx, input logic f,
		input logic [15:0] cw);
		logic [9:0] z;
		logic [9:0] off;
		logic [9:0] p;
		logic [3:0] rev;
		logic [71:0] ck_l;
		logic [55:0] ck_s;
		rev  = `ASR_REV_ID;
		ck_l = `ASR_CHK_L;
		ck_s = `ASR_CHK_S;
		z   = f ? `ASR_RB_ZERO_L : `ASR_RB_ZERO_S;
		off = idx - z;
		p   = (f ? `ASR_RB_LEN_L : `ASR_RB_LEN_S) - 10'h001 - idx;
		if (idx < z)
			rb_bit = 1'b0;
		else if (off < 10'h010)
			rb_bit = cw[4'hF - off[3:0]];
		else if (off < 10'h014)
			rb_bit = rev[2'h3 - off[1:0]];
		else if (f)
			rb_bit = (p < `ASR_CHK_W_L) ? ck_l[p[6:0]] : 1'b0;
		else
			rb_bit = (p < `ASR_CHK_W_S) ? ck_s[p[5:0]] : 1'b0;
	endfunction

	// chain input delay line, sampled on falling edges
	always_ff @(negedge readout_clk_i)
	begin
		chain_sr_ff <= {chain_sr_ff[1278:0], chain_in_i};
	end

	// result shifter: own 64 words first, then the chained stream
	always_ff @(negedge readout_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			own_word_ff <= 6'h00;
			own_bit_ff  <= 5'h00;
			own_done_ff <= 1'b0;
			started_ff  <= 1'b0;
			dat_out_ff  <= 1'b0;
		end
		else
		begin
			started_ff <= 1'b1;
			if (!own_done_ff)
			begin
				dat_out_ff <= own_bit_w;
				own_done_ff <= own_last;
				own_bit_ff  <= (own_bit_ff == wbit_last) ? 5'h00 : own_bit_ff + 5'h01;
				if (own_bit_ff == wbit_last)
					own_word_ff <= own_word_ff + 6'h01;
			end
			else
				dat_out_ff <= chain_tap_d;
		end
	end

	// readback shifter on rising edges: two passes, then chain
	always_ff @(posedge readout_clk_i or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			rb_idx_ff  <= 10'h000;
			rb_rep_ff  <= 1'b0;
			rb_pass_ff <= 1'b0;
			rb_out_ff  <= 1'b0;
		end
		else if (rb_pass_ff)
			rb_out_ff <= chain_tap_r;
		else
		begin
			rb_out_ff <= rb_bit(rb_idx_ff, fmt, cfg_ff);
			rb_idx_ff <= (rb_idx_ff == rb_len_last) ? 10'h000 : rb_idx_ff + 10'h001;
			if (rb_idx_ff == rb_len_last)
			begin
				rb_rep_ff  <= 1'b1;
				rb_pass_ff <= rb_rep_ff;
			end
		end
	end

	// outputs; the readback select only moves while the link is quiet
	assign serial_out_o   = rb_sel_ff ? rb_out_ff : dat_out_ff;
	assign data_ready_n_o = data_ready_n_ff;
	assign overrun_o      = overrun_ff;
	assign cfg_word_o     = cfg_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_go;
		frame_go;
	endsequence

	sequence s_last_cfg;
		cfg_commit;
	endsequence

	property p_ready_fall;
		@(posedge clock_i) disable iff (!rstn_i)
		(ce_i && hold_cnt_ff == 7'h01 && !frame_go) |=> !data_ready_n_o;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready not low");

	property p_ready_rise;
		@(posedge clock_i) disable iff (!rstn_i)
		(ce_i && st_s2_ff && hold_cnt_ff == 7'h00 && !frame_go) |=> data_ready_n_o;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready not released");

	property p_hold_quiet;
		@(posedge clock_i) disable iff (!rstn_i)
		s_go |=> data_ready_n_o [*8];
	endproperty
	a_hold_quiet: assert property (p_hold_quiet) else $error("ready fell too early");

	property p_cfg_commit;
		@(posedge clock_i) disable iff (!rstn_i)
		s_last_cfg |=> (cfg_ff[0] == $past(cfgd_s2_ff)) && (mode_ff == asr_pkg::ASR_RB);
	endproperty
	a_cfg_commit: assert property (p_cfg_commit) else $error("config word not taken");

	property p_no_partial;
		@(posedge clock_i) disable iff (!rstn_i)
		(cfg_take && !cfg_commit) |=> $stable(cfg_ff);
	endproperty
	a_no_partial: assert property (p_no_partial) else $error("partial config write");

	property p_overrun;
		@(posedge clock_i) disable iff (!rstn_i)
		(frame_go && have_frame_ff && !od_s2_ff) |=> overrun_o;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_own_bit;
		@(negedge readout_clk_i) disable iff (!lrst_n_ff)
		!own_done_ff |=> dat_out_ff == $past(own_bit_w);
	endproperty
	a_own_bit: assert property (p_own_bit) else $error("wrong result bit");

	property p_chain_pass;
		@(negedge readout_clk_i) disable iff (!lrst_n_ff)
		own_done_ff |=> dat_out_ff == $past(chain_tap_d);
	endproperty
	a_chain_pass: assert property (p_chain_pass) else $error("chain bit lost");

	property p_rb_zero;
		@(posedge readout_clk_i) disable iff (!lrst_n_ff)
		(!rb_pass_ff && rb_idx_ff < `ASR_RB_ZERO_S) |=> !rb_out_ff;
	endproperty
	a_rb_zero: assert property (p_rb_zero) else $error("readback prefix not zero");

	property p_rb_end;
		@(posedge readout_clk_i) disable iff (!lrst_n_ff)
		(!rb_pass_ff && fmt && rb_idx_ff == rb_len_last) |=> rb_out_ff;
	endproperty
	a_rb_end: assert property (p_rb_end) else $error("check tail wrong");

	property p_rb_twice;
		@(posedge readout_clk_i) disable iff (!lrst_n_ff)
		$rose(rb_pass_ff) |-> $past(rb_rep_ff);
	endproperty
	a_rb_twice: assert property (p_rb_twice) else $error("readback not repeated");

endmodule

`default_nettype wire

// >>> verif/asr_host.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host controller model: link clock, config pins, upstream
// ------------------------------------------------------------
module asr_host (
	// pins driven toward the device
	output logic      readout_clk_o,
	output logic      cfg_clk_o,
	output logic      cfg_din_o,
	output logic      isel_o,
	output logic      chain_o,
	// pins watched from the device
	input  wire logic serial_out_i,
	input  wire logic data_ready_n_i
);
	logic obs [0:1295]; // one sample per link clock step
	logic rdy_first;    // ready level just after the first fall
	// clocks idle low, select low for config, chain low when idle
	initial
	begin
		readout_clk_o = 1'b0;
		cfg_clk_o = 1'b0;
		cfg_din_o = 1'b0;
		isel_o = 1'b0;
		chain_o = 1'b0;
	end
	// upstream pattern changes every few steps so a slip shows
	function automatic logic cf(input logic [31:0] j);
		return j[1] ^ j[3];
	endfunction
	// msb first; nb below 16 only when a refusal is wanted
	task automatic cfg_write(input logic [15:0] w, input int nb);
		#2000;
		for (int i = 15; i > 15 - nb; i--)
		begin
			cfg_din_o = w[i];
			#40 cfg_clk_o = 1'b1;
			#40 cfg_clk_o = 1'b0;
			#40;
		end
		cfg_din_o = ~cfg_din_o; // hold is over, line means nothing now
		#2000;
	endtask
	// link clock stays quiet on both sides of the select edge
	task automatic toggle_isel();
		#2000;
		isel_o = ~isel_o;
		#2000;
	endtask
	// n pulses; rb samples after the rise, else after the fall
	task automatic shift(input int n, input bit rb);
		#3;
		for (int j = 1; j <= n; j++)
		begin
			readout_clk_o = 1'b1;
			#40;
			if (rb)
				obs[j-1] = serial_out_i;
			#40 readout_clk_o = 1'b0;
			#40;
			if (!rb)
				obs[j-1] = serial_out_i;
			if (j == 1)
				rdy_first = data_ready_n_i;
			chain_o = cf(32'(j));
			#40;
		end
	endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "asr_map.svh"
// ------------------------------------------------------------
// readout and configuration bench
// ------------------------------------------------------------
module testbench;
	logic        clock_i;
	logic        rstn_i;
	logic        res_wr_i;
	logic [5:0]  res_ch_i;
	logic [19:0] res_data_i;
	logic        frame_done_i;
	wire         rclk, cfg_clk, cfg_din, isel, chain, dout, rdy_n, ovr;
	wire  [15:0] cfg_word;
	int          fails;
	int          checked;
	// only the clock enable is tied: the whole block runs
	asr_readout u_asr_readout (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
		.readout_clk_i(rclk), .res_wr_i(res_wr_i), .res_ch_i(res_ch_i),
		.res_data_i(res_data_i), .frame_done_i(frame_done_i),
		.integrate_select_i(isel), .cfg_shift_clk_i(cfg_clk),
		.cfg_serial_in_i(cfg_din), .chain_in_i(chain), .data_ready_n_o(rdy_n),
		.serial_out_o(dout), .overrun_o(ovr), .cfg_word_o(cfg_word));
	asr_host u_host (.readout_clk_o(rclk), .cfg_clk_o(cfg_clk), .cfg_din_o(cfg_din),
		.isel_o(isel), .chain_o(chain), .serial_out_i(dout), .data_ready_n_i(rdy_n));
	// system clock, 8 ns
	always #4 clock_i = ~clock_i;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// reset values are looked at while reset is still held
	task automatic do_reset();
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		check("ready_rst", rdy_n, 1);
		check("ovr_rst", ovr, 0);
		check("cfg_rst", cfg_word, `ASR_CFG_RST);
		rstn_i <= 1'b1;
	endtask
	task automatic pulse_done();
		@(posedge clock_i);
		frame_done_i <= 1'b1;
		@(posedge clock_i);
		frame_done_i <= 1'b0;
	endtask
	// result word of channel c, distinct per channel
	function automatic logic [19:0] dw(input logic [5:0] c);
		return {c, 8'hA5, ~c};
	endfunction
	// bit k of the readback stream, pass repeated
	function automatic logic rb_bit(input int k, input bit fmt, input logic [15:0] w);
		int          p;
		int          z;
		logic [71:0] tl;
		logic [3:0]  rev;
		p = fmt ? `ASR_RB_LEN_L : `ASR_RB_LEN_S;
		z = fmt ? `ASR_RB_ZERO_L : `ASR_RB_ZERO_S;
		tl = fmt ? `ASR_CHK_L : {16'h0000, `ASR_CHK_S};
		rev = `ASR_REV_ID;
		k = k % p;
		if (k < z)
			return 1'b0;
		if (k < z + 16)
			return w[15-(k-z)];
		if (k < z + 20)
			return rev[3-(k-z-16)];
		if (k >= p - (fmt ? `ASR_CHK_W_L : `ASR_CHK_W_S))
			return tl[p-1-k];
		return 1'b0;
	endfunction
	// a short word must never reach the register
	task automatic t_partial();
		u_host.cfg_write(16'hFFFF, 15);
		check("cfg_partial", cfg_word, 16'h0000);
	endtask
	// write, then the double readback pass and the chained tail
	task automatic t_readback(input bit fmt, input logic [15:0] w);
		int n;
		int errs;
		logic e_bit;
		do_reset();
		u_host.cfg_write(w, 16);
		check("cfg_word", cfg_word, w);
		n = 2 * (fmt ? `ASR_RB_LEN_L : `ASR_RB_LEN_S);
		u_host.shift(n + 16, 1'b1);
		errs = 0;
		for (int e = 1; e <= n + 16; e++)
		begin
			e_bit = (e <= n) ? rb_bit(e - 1, fmt, w) : u_host.cf(32'(e - n - 1));
			if (u_host.obs[e-1] !== e_bit)
				errs++;
		end
		check("readback", errs, 0);
	endtask
	// one frame of results read out whole, then the overrun case
	task automatic t_data();
		int n;
		int errs;
		logic [19:0] w;
		u_host.toggle_isel();
		for (int c = 0; c < 64; c++)
		begin
			@(posedge clock_i);
			res_wr_i <= 1'b1;
			res_ch_i <= 6'(c);
			res_data_i <= dw(6'(c));
		end
		@(posedge clock_i);
		res_wr_i <= 1'b0;
		pulse_done();
		n = 0;
		while (rdy_n !== 1'b0 && n < 200)
		begin
			@(negedge clock_i);
			n++;
		end
		check("ready_delay", 32'(n >= 48 && n <= 52), 1);
		u_host.shift(1296, 1'b0);
		check("ready_release", u_host.rdy_first, 1);
		errs = 0;
		for (int e = 1; e <= 1296; e++)
		begin
			w = dw(6'((e - 1) / 20));
			if (u_host.obs[e-1] !== ((e <= 1280) ? w[19-(e-1)%20] : u_host.cf(32'(e - 1280))))
				errs++;
		end
		check("data_stream", errs, 0);
		pulse_done();
		repeat (3) @(posedge clock_i);
		check("ovr_after_read", ovr, 0);
		pulse_done();
		repeat (3) @(posedge clock_i);
		check("ovr_unread", ovr, 1);
	endtask
	// main sequence
	initial
	begin
		clock_i = 1'b0;
		rstn_i = 1'b1;
		res_wr_i = 1'b0;
		res_ch_i = 6'h00;
		res_data_i = 20'h00000;
		frame_done_i = 1'b0;
		fails = 0;
		checked = 0;
		do_reset();
		t_partial();
		t_readback(1'b0, 16'h2600);
		t_readback(1'b1, 16'h0781);
		t_data();
		report_and_stop();
	end
	// watchdog well past the expected run length
	initial
	begin
		#760000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
